// file: common/iael_defs.vh
/*
 * constants for the interrupt acceptance and enable block: special
 * register offsets, reset values, vector table layout and sequence counts.
 * assumes an 8-bit special-register space and a 20-bit program counter.
 */
`ifndef IAEL_DEFS_VH
`define IAEL_DEFS_VH

// ==========================================================
// special register offsets
`define IAEL_ADR_EN_EXT 8'h2c
`define IAEL_ADR_EN_TOP 8'h2d
`define IAEL_ADR_EN_LOW 8'h3a
`define IAEL_ADR_EN_HIGH 8'h3b
`define IAEL_ADR_RL_LOW 8'h3c
`define IAEL_ADR_RL_HIGH 8'h3d
`define IAEL_ADR_RL_EXT 8'h2e
`define IAEL_ADR_RL_TOP 8'h2f

// ==========================================================
// field positions and reset values
`define IAEL_IMF_BIT 0
`define IAEL_IMF_RST 1'b0
`define IAEL_EF_RST 14'h0000
`define IAEL_BANK_RST 4'h0

// ==========================================================
// vector table and sequence
`define IAEL_VEC_TOP 20'hffffc
`define IAEL_VEC_SOFT 5'h01
`define IAEL_VEC_WDOG 5'h02
`define IAEL_ACC_CYCLES 4'hc
`define IAEL_PUSH_LAST 4'h4
`define IAEL_VRD_FIRST 4'h5
`define IAEL_VRD_LAST 4'h8
`define IAEL_RET_LAST 4'h6

`endif

// file: design/iael_ctrl.v
/*
 * interrupt acceptance and enable logic: master and per-source accept
 * flags, request latches, pseudo non-maskable traps, the 12-cycle
 * acceptance sequence and the return sequence.
 * assumes core and peripherals on clk; vector and stack data arrive the
 * cycle after the read strobe; instr_last marks an instruction's last cycle.
 */
// Function
// RQ1: soft and watchdog traps ignore enables; such traps never nest.
// RQ2: enable bytes readable and writable by instructions, bit operations too.
// RQ3: master flag 0 blocks maskable requests; 1 lets per-source flags decide.
// RQ4: accepting any interrupt clears the master flag.
// RQ5: maskable return sets master flag; pending request then serviced at once.
// RQ6: trap return sets master flag only if it was 1 and untouched.
// RQ7: software avoids bit operations on low enable byte during trap service.
// RQ8: master flag is bit 0 of low enable byte, set/cleared by ops, resets 0.
// RQ9: sources 3 to 16 each have an accept flag, 1 permits.
// RQ10: request latch holds until accepted, reset, or cleared by instruction.
// RQ11: acceptance takes 12 cycles after the current instruction completes.
// RQ12: acceptance clears the latch of the accepted source.
// RQ13: push status high, low, pc ext, high, low; stack pointer down five.
// RQ14: entry address read from the source's vector slot into pc.
// RQ15: bank code read after entry; its low four bits added to bank select.
// RQ16: accepting a trap blocks all further acceptance for a while.
// RQ17: master flag 0 blocks even higher priority maskable requests.
// RQ18: only pc and status word are saved automatically.
// RQ19: both returns restore the bank select that was in force.
// RQ20: among pending enabled requests, the lowest index wins.
// RQ21: latches readable, cleared by writing 0, never set by software; writing 0 does not clear latch 2 (watchdog).
// RQ22: requests sampled in the last cycle of each instruction.
// RQ23: returns restore pc and status word, stack pointer up five.
// RQ24: one request plus winning vector index, held until acceptance ends.
`timescale 1ns/10ps
`include "iael_defs.vh"

module iael_ctrl (
  input wire clk,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  input wire [16:2] irq_set,
  input wire instr_last,
  input wire soft_trap_op,
  input wire unmask_all_op,
  input wire mask_all_op,
  input wire maskable_return_op,
  input wire nonmaskable_return_op,
  input wire [15:0] status_word,
  input wire [19:0] pc_in,
  input wire [7:0] vec_rdata,
  input wire [7:0] stk_rdata,
  output reg int_pend_q,
  output reg int_busy_q,
  output reg [4:0] int_vec_q,
  output reg stk_wr_q,
  output reg [7:0] stk_wdata_q,
  output reg sp_dec_q,
  output reg stk_rd_q,
  output reg sp_inc_q,
  output reg vec_rd_q,
  output reg [19:0] vec_addr_q,
  output reg pc_load_q,
  output reg [19:0] pc_new_q,
  output reg status_load_q,
  output reg [15:0] status_new_q,
  output reg [3:0] bank_select_field_q,
  output reg master_accept_flag_q,
  output reg trap_active_q
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ACC = 3'b010;
  localparam [2:0] ST_RET = 3'b100;

  reg [2:0] st_q;
  reg [3:0] cnt_q;
  reg ret_trap_q;
  reg trap_imf_q;
  reg [16:2] request_latch_q;
  reg [16:3] source_accept_flags_q;
  reg [16:2] il_wclr;
  reg win_ok;
  reg [4:0] win_idx;
  reg [7:0] rd_mux;
  reg [7:0] push_byte;
  integer i;

  wire idle = st_q[0];
  wire soft_take = idle & soft_trap_op & ~trap_active_q; // [RQ1]
  wire acc_start = soft_take | (idle & instr_last & win_ok); // [RQ22]
  wire [4:0] acc_vec = soft_take ? `IAEL_VEC_SOFT : win_idx;
  wire wr_low = sfr_wr & (sfr_addr == `IAEL_ADR_EN_LOW);
  wire wr_high = sfr_wr & (sfr_addr == `IAEL_ADR_EN_HIGH);
  wire wr_ext = sfr_wr & (sfr_addr == `IAEL_ADR_EN_EXT);
  wire [19:0] vec_base = `IAEL_VEC_TOP - {13'h0000, int_vec_q, 2'b00};
  wire ret_done = st_q[2] & (cnt_q == `IAEL_RET_LAST);
  wire sw_imf_clr = mask_all_op | (wr_low & ~sfr_wdata[`IAEL_IMF_BIT]);

  // ==========================================================
  // winner selection
  always @* begin
    win_ok = 1'b0;
    win_idx = 5'h00;
    for (i = 16; i >= 3; i = i - 1) begin
      if (request_latch_q[i] & source_accept_flags_q[i] & master_accept_flag_q) begin // [RQ3] [RQ9] [RQ17]
        win_ok = 1'b1;
        win_idx = i[4:0]; // [RQ20]
      end
    end
    if (request_latch_q[2]) begin
      win_ok = 1'b1; // [RQ1]
      win_idx = `IAEL_VEC_WDOG;
    end
    if (trap_active_q) begin
      win_ok = 1'b0; // [RQ16]
    end
  end

  // ==========================================================
  // request latches
  genvar g;
  generate
    for (g = 2; g <= 16; g = g + 1) begin : gen_latch
      localparam [7:0] LADR = (g < 8) ? `IAEL_ADR_RL_LOW :
                              (g < 16) ? `IAEL_ADR_RL_HIGH : `IAEL_ADR_RL_EXT;
      always @* begin
        il_wclr[g] = (g != 2) && sfr_wr && (sfr_addr == LADR) && !sfr_wdata[g % 8]; // [RQ21]
      end
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          request_latch_q[g] <= 1'b0;
        end else if (irq_set[g]) begin
          request_latch_q[g] <= 1'b1;
        end else if ((acc_start && !soft_take && win_idx == g) || il_wclr[g]) begin
          request_latch_q[g] <= 1'b0; // [RQ10] [RQ12]
        end
      end
    end
  endgenerate

  // ==========================================================
  // register read path
  always @* begin
    case (sfr_addr)
      `IAEL_ADR_EN_LOW: rd_mux = {source_accept_flags_q[7:3], 2'b00, master_accept_flag_q};
      `IAEL_ADR_EN_HIGH: rd_mux = source_accept_flags_q[15:8];
      `IAEL_ADR_EN_EXT: rd_mux = {7'h00, source_accept_flags_q[16]};
      `IAEL_ADR_RL_LOW: rd_mux = {request_latch_q[7:2], 2'b00};
      `IAEL_ADR_RL_HIGH: rd_mux = request_latch_q[15:8];
      `IAEL_ADR_RL_EXT: rd_mux = {7'h00, request_latch_q[16]};
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_q <= rd_mux; // [RQ2] [RQ21]
    end
  end

  // ==========================================================
  // enable flags and master flag
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      source_accept_flags_q <= `IAEL_EF_RST;
    end else begin
      if (wr_low) begin
        source_accept_flags_q[7:3] <= sfr_wdata[7:3]; // [RQ2] [RQ9]
      end
      if (wr_high) begin
        source_accept_flags_q[15:8] <= sfr_wdata;
      end
      if (wr_ext) begin
        source_accept_flags_q[16] <= sfr_wdata[0];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      master_accept_flag_q <= `IAEL_IMF_RST; // [RQ8]
    end else if (acc_start) begin
      master_accept_flag_q <= 1'b0; // [RQ4]
    end else if (ret_done) begin
      master_accept_flag_q <= ret_trap_q ? trap_imf_q : 1'b1; // [RQ5] [RQ6]
    end else if (mask_all_op) begin
      master_accept_flag_q <= 1'b0; // [RQ8]
    end else if (unmask_all_op) begin
      master_accept_flag_q <= 1'b1;
    end else if (wr_low) begin
      master_accept_flag_q <= sfr_wdata[`IAEL_IMF_BIT]; // [RQ8]
    end
  end

  // trap nesting state and the master flag to give back on trap return
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trap_active_q <= 1'b0;
      trap_imf_q <= 1'b0;
    end else if (acc_start && acc_vec <= `IAEL_VEC_WDOG) begin
      trap_active_q <= 1'b1; // [RQ1] [RQ16]
      trap_imf_q <= master_accept_flag_q; // [RQ6]
    end else if (ret_done && ret_trap_q) begin
      trap_active_q <= 1'b0;
    end else if (trap_active_q && sw_imf_clr) begin
      trap_imf_q <= 1'b0; // [RQ6] [RQ7]
    end
  end

  // ==========================================================
  // acceptance and return sequencer
  always @* begin
    case (cnt_q)
      4'h0: push_byte = {status_word[15:12], bank_select_field_q};
      4'h1: push_byte = status_word[7:0];
      4'h2: push_byte = {4'h0, pc_in[19:16]};
      4'h3: push_byte = pc_in[15:8];
      default: push_byte = pc_in[7:0];
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      ret_trap_q <= 1'b0;
      int_pend_q <= 1'b0;
      int_busy_q <= 1'b0;
      int_vec_q <= 5'h00;
      stk_wr_q <= 1'b0;
      stk_wdata_q <= 8'h00;
      sp_dec_q <= 1'b0;
      stk_rd_q <= 1'b0;
      sp_inc_q <= 1'b0;
      vec_rd_q <= 1'b0;
      vec_addr_q <= 20'h00000;
      pc_load_q <= 1'b0;
      pc_new_q <= 20'h00000;
      status_load_q <= 1'b0;
      status_new_q <= 16'h0000;
      bank_select_field_q <= `IAEL_BANK_RST;
    end else begin
      stk_wr_q <= 1'b0;
      sp_dec_q <= 1'b0;
      stk_rd_q <= 1'b0;
      sp_inc_q <= 1'b0;
      vec_rd_q <= 1'b0;
      pc_load_q <= 1'b0;
      status_load_q <= 1'b0;
      cnt_q <= cnt_q + 4'h1;
      case (st_q)
        ST_IDLE: begin
          cnt_q <= 4'h0;
          int_pend_q <= win_ok | acc_start; // [RQ24]
          int_vec_q <= acc_start ? acc_vec : win_idx;
          if (acc_start) begin
            st_q <= ST_ACC; // [RQ11]
            int_busy_q <= 1'b1;
          end else if (maskable_return_op || nonmaskable_return_op) begin
            st_q <= ST_RET;
            ret_trap_q <= nonmaskable_return_op;
          end
        end
        ST_ACC: begin
          if (cnt_q <= `IAEL_PUSH_LAST) begin
            stk_wr_q <= 1'b1; // [RQ13] [RQ18]
            sp_dec_q <= 1'b1;
            stk_wdata_q <= push_byte;
          end
          if (cnt_q >= `IAEL_VRD_FIRST && cnt_q <= `IAEL_VRD_LAST) begin
            vec_rd_q <= 1'b1;
            vec_addr_q <= vec_base + {18'h00000, cnt_q[1:0] - 2'b01};
          end
          if (cnt_q == 4'h7) begin
            pc_new_q[7:0] <= vec_rdata; // [RQ14]
          end
          if (cnt_q == 4'h8) begin
            pc_new_q[15:8] <= vec_rdata;
          end
          if (cnt_q == 4'h9) begin
            pc_new_q[19:16] <= vec_rdata[3:0];
          end
          if (cnt_q == 4'ha) begin
            bank_select_field_q <= bank_select_field_q + vec_rdata[3:0]; // [RQ15]
            pc_load_q <= 1'b1; // [RQ14]
          end
          if (cnt_q == `IAEL_ACC_CYCLES - 4'h1) begin
            st_q <= ST_IDLE; // [RQ11]
            int_busy_q <= 1'b0;
            int_pend_q <= 1'b0;
          end
        end
        ST_RET: begin
          if (cnt_q <= `IAEL_PUSH_LAST) begin
            stk_rd_q <= 1'b1; // [RQ23]
            sp_inc_q <= 1'b1;
          end
          if (cnt_q == 4'h2) begin
            pc_new_q[7:0] <= stk_rdata;
          end
          if (cnt_q == 4'h3) begin
            pc_new_q[15:8] <= stk_rdata;
          end
          if (cnt_q == 4'h4) begin
            pc_new_q[19:16] <= stk_rdata[3:0];
          end
          if (cnt_q == 4'h5) begin
            status_new_q[7:0] <= stk_rdata;
          end
          if (ret_done) begin
            status_new_q[15:8] <= stk_rdata;
            bank_select_field_q <= stk_rdata[3:0]; // [RQ19]
            pc_load_q <= 1'b1; // [RQ23]
            status_load_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // iael_ctrl

// file: verif/iael_core_model.sv
/* stack and vector memory standing in for the core side.
   assumes strobes from iael_ctrl; data answered the cycle after. */
`timescale 1ns/10ps
module iael_core_model (
  input wire clk,
  input wire stk_wr_q,
  input wire [7:0] stk_wdata_q,
  input wire stk_rd_q,
  input wire vec_rd_q,
  input wire [19:0] vec_addr_q,
  output logic [7:0] vec_rdata = 8'h00,
  output logic [7:0] stk_rdata = 8'h00
);
  logic [7:0] mem [0:15];
  logic [3:0] sp = 4'h0;
  // ========
  // last in first out stack; idle data lines toggle
  always @(posedge clk) begin
    stk_rdata <= ~stk_rdata;
    vec_rdata <= ~vec_rdata;
    if (stk_wr_q) begin
      mem[sp] <= stk_wdata_q;
      sp <= sp + 4'h1;
    end
    if (stk_rd_q) begin
      stk_rdata <= mem[sp - 4'h1];
      sp <= sp - 4'h1;
    end
    // vector byte is the low address byte
    if (vec_rd_q)
      vec_rdata <= vec_addr_q[7:0];
  end
endmodule // iael_core_model

// file: verif/iael_ctrl_chk.sv
/* timing checks for iael_ctrl acceptance and return.
   assumes the ports of iael_ctrl on one clock. */
`timescale 1ns/10ps
module iael_ctrl_chk (
  input wire clk,
  input wire rst,
  input wire maskable_return_op,
  input wire nonmaskable_return_op,
  input wire int_busy_q,
  input wire [4:0] int_vec_q,
  input wire stk_wr_q,
  input wire sp_dec_q,
  input wire stk_rd_q,
  input wire sp_inc_q,
  input wire vec_rd_q,
  input wire [19:0] vec_addr_q,
  input wire pc_load_q,
  input wire master_accept_flag_q,
  input wire trap_active_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ========
  // acceptance
  property p_len;
    $rose(int_busy_q) |-> int_busy_q[*8] ##1 int_busy_q[*4] ##1 !int_busy_q;
  endproperty
  a_len: assert property (p_len) else $error("accept length");
  property p_imf;
    $rose(int_busy_q) |-> !master_accept_flag_q && !$past(trap_active_q);
  endproperty
  a_imf: assert property (p_imf) else $error("accept flags");
  property p_msk;
    $rose(int_busy_q) && int_vec_q > 5'h2 |-> $past(master_accept_flag_q);
  endproperty
  a_msk: assert property (p_msk) else $error("masked accept");
  property p_push;
    $rose(int_busy_q) |-> ##1 (stk_wr_q && sp_dec_q)[*5] ##1 !stk_wr_q;
  endproperty
  a_push: assert property (p_push) else $error("push count");
  property p_vec;
    vec_rd_q |-> vec_addr_q[19:2] == 18'h3ffff - int_vec_q;
  endproperty
  a_vec: assert property (p_vec) else $error("vector slot");
  property p_hold;
    int_busy_q && $past(int_busy_q) |-> $stable(int_vec_q);
  endproperty
  a_hold: assert property (p_hold) else $error("index moved");
  // ========
  // return
  property p_pop;
    (maskable_return_op || nonmaskable_return_op) && !int_busy_q && !stk_rd_q
      |-> ##2 (stk_rd_q && sp_inc_q)[*5] ##1 !stk_rd_q;
  endproperty
  a_pop: assert property (p_pop) else $error("pop count");
  property p_maskable_return_op;
    maskable_return_op && !int_busy_q && !stk_rd_q
      |-> ##[6:8] (pc_load_q && master_accept_flag_q);
  endproperty
  a_maskable_return_op: assert property (p_maskable_return_op) else $error("return flag");
endmodule // iael_ctrl_chk
bind iael_ctrl iael_ctrl_chk iael_ctrl_chk_inst (.clk, .rst, .maskable_return_op,
  .nonmaskable_return_op, .int_busy_q, .int_vec_q, .stk_wr_q, .sp_dec_q, .stk_rd_q,
  .sp_inc_q, .vec_rd_q, .vec_addr_q, .pc_load_q, .master_accept_flag_q, .trap_active_q);

// file: verif/tb_interrupt_accept_enable_logic.sv
/* testbench for iael_ctrl: registers, acceptance, traps, returns.
   assumes iael_core_model on the stack and vector side. */
`timescale 1ns/10ps
`include "iael_defs.vh"
module tb_interrupt_accept_enable_logic;
  logic clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, instr_last = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [16:2] irq = 15'h0000;
  logic [4:0] ops = 5'h00;
  wire [7:0] sfr_rdata_q, vec_rdata, stk_rdata, stk_wdata_q;
  wire int_busy_q, stk_wr_q, stk_rd_q, vec_rd_q, pc_load_q, master_accept_flag_q;
  wire int_pend_q, status_load_q;
  wire [4:0] int_vec_q;
  wire [19:0] vec_addr_q, pc_new_q;
  wire [15:0] status_new_q;
  wire [3:0] bank_select_field_q;
  logic [7:0] pv [0:4] = '{8'h50, 8'h3c, 8'h01, 8'h23, 8'h45};
  logic [19:0] vb;
  int fails = 0, samples_checked = 0, i;
  iael_ctrl iael_ctrl_inst (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata_q, .irq_set(irq), .instr_last, .soft_trap_op(ops[0]),
    .unmask_all_op(ops[1]), .mask_all_op(ops[2]), .maskable_return_op(ops[3]),
    .nonmaskable_return_op(ops[4]), .status_word(16'h5a3c), .pc_in(20'h12345),
    .vec_rdata, .stk_rdata, .int_pend_q, .int_busy_q, .int_vec_q, .stk_wr_q,
    .stk_wdata_q, .sp_dec_q(), .stk_rd_q, .sp_inc_q(), .vec_rd_q, .vec_addr_q, .pc_load_q,
    .pc_new_q, .status_load_q, .status_new_q, .bank_select_field_q,
    .master_accept_flag_q, .trap_active_q());
  iael_core_model iael_core_model_inst (.clk, .stk_wr_q, .stk_wdata_q, .stk_rd_q,
    .vec_rd_q, .vec_addr_q, .vec_rdata, .stk_rdata);
  always #50 clk = ~clk;
  // ========
  // tasks
  task chk(input logic [19:0] g, input logic [19:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clk);
    sfr_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1;
    @(negedge clk);
    sfr_rd = 0;
    @(negedge clk);
    chk(sfr_rdata_q, e);
  endtask
  // one-cycle pulse: 0 trap, 1 unmask, 2 mask, 3 maskable ret, 4 trap ret
  task pl(input int k);
    @(negedge clk);
    ops = 5'h01 << k;
    @(negedge clk);
    ops = 5'h00;
  endtask
  task pi(input logic [16:2] m);
    @(negedge clk);
    irq = m;
    @(negedge clk);
    irq = 15'h0000;
  endtask
  // wait for 0 busy, 1 idle, 2 pc load
  task wt(input int k);
    int n;
    for (n = 0; n < 40; n++) begin
      if ((k == 0 && int_busy_q === 1) || (k == 1 && int_busy_q === 0) ||
          (k == 2 && pc_load_q === 1))
        break;
      @(negedge clk);
    end
    chk(n < 40, 1);
  endtask
  task wrap_up;
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ========
  // tests
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    rd(8'h3a, 8'h00);
    rd(8'h2d, 8'h00);
    rd(8'h50, 8'h00);
    wr(8'h2c, 8'hff);
    rd(8'h2c, 8'h01);
    wr(8'h3b, 8'h02);
    rd(8'h3b, 8'h02);
    pi(15'h0088);
    instr_last = 1;
    repeat (3) @(negedge clk);
    chk(int_busy_q, 0);
    rd(8'h3c, 8'h20);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h20);
    wr(8'h3a, 8'hf8);
    rd(8'h3a, 8'hf8);
    instr_last = 0;
    pl(1);
    repeat (3) @(negedge clk);
    chk(int_busy_q, 0);
    chk(int_pend_q, 1);
    instr_last = 1;
    wt(0);
    chk(int_vec_q, 5);
    chk(master_accept_flag_q, 0);
    wt(1);
    for (i = 0; i < 5; i++)
      chk(iael_core_model_inst.mem[i], pv[i]);
    vb = `IAEL_VEC_TOP - 20'h00014;
    chk(pc_new_q, {vb[3:0] | 4'h2, vb[7:0] | 8'h01, vb[7:0]});
    chk(bank_select_field_q, vb[3:0] | 4'h3);
    rd(8'h3c, 8'h00);
    pl(3);
    wt(2);
    chk(pc_new_q, 20'h12345);
    chk(status_new_q, 16'h503c);
    chk(status_load_q, 1);
    chk(bank_select_field_q, 0);
    chk(master_accept_flag_q, 1);
    wt(0);
    chk(int_vec_q, 9);
    wt(1);
    pl(1);
    pl(0);
    wt(0);
    chk(int_vec_q, 1);
    wt(1);
    pl(0);
    pi(15'h0001);
    repeat (3) @(negedge clk);
    chk(int_busy_q, 0);
    pl(4);
    wt(2);
    chk(master_accept_flag_q, 1);
    wt(0);
    chk(int_vec_q, 2);
    wt(1);
    pl(2);
    pl(4);
    wt(2);
    chk(master_accept_flag_q, 0);
    // ========
    // reset in mid-run drops a pending latch and the enables
    pi(15'h0010);
    rd(8'h3c, 8'h40);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    rd(8'h3c, 8'h00);
    rd(8'h3a, 8'h00);
    wrap_up;
  end
  initial begin
    #1000000;
    fails++;
    wrap_up;
  end
endmodule // tb_interrupt_accept_enable_logic
